// [design/bridge_cfg_translation_slot_regs.sv]
// Translation window and slot identification configuration registers.
// Assumes an Avalon-MM master with waitrequest on the same clock.
// What this block does
// - Bit 22 of the support extension dword reads 0 and is read-only.
// - Bit 23 of the support extension dword reads 0 and is read-only.
// - The top byte of the support extension dword reads 0, ignores writes.
// - Bits 31:12 at 0x98 hold a base, writable only where the window mask is set; low 12 bits read zero.
// - The setup size mask picks which base bits replace address bits.
// - Setup bit 0 reads 0, meaning a memory window.
// - Setup bits 2:1 give address type, 00 for 32-bit, 01 for 64-bit.
// - The enable bit stays 1 even when zero is written to it.
// - At the smallest window a sizing read gives ones in bits 31:12.
// - The slot capability code 04h reads in bits 7:0.
// - The next link B0h reads in bits 15:8.
// - A writable slot number and first flag, reserved bits 23:22 zero.
// - A writable chassis number sits in bits 31:24, resetting to zero.
`timescale 1ns/1ps
`default_nettype none

module bridge_cfg_translation_slot_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire bridge_cfg_pkg::avs_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic [1:0] avs_response,
    output logic avs_waitrequest,
    input wire logic init_wr_en,
    input wire bridge_cfg_pkg::win_setup_t init_setup,
    input wire logic dn_valid,
    input wire logic [31:0] dn_addr,
    input wire logic [31:0] win_base,
    output logic dn_hit_ff,
    output logic [31:0] xlat_addr_ff,
    output logic [31:0] bar_rw_mask_ff,
    output logic [31:0] bar_size_read_ff
);
    import bridge_cfg_pkg::*;

    logic ack_ff;
    logic req_taken;
    logic wr_done;
    logic [31:0] avs_readdata_ff;
    logic [1:0] avs_response_ff;
    logic [19:0] xbase_ff;
    logic [19:0] nxt_xbase;
    win_setup_t setup_ff;
    win_setup_t nxt_setup;
    logic [4:0] slot_num_ff;
    logic first_ff;
    logic [7:0] chassis_ff;
    logic [31:0] slot_word;
    logic [31:0] slot_merged;
    logic [31:0] base_merged;
    logic [19:0] win_mask;
    logic [31:0] rd_word;
    logic rd_mapped;

    // Expand byte enables into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // Merge writable bits of enabled lanes into an old word
    function automatic logic [31:0] merge_word(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] be,
        input logic [31:0] wmask
    );
        logic [31:0] m;
        m = lane_mask(be) & wmask;
        return (old & ~m) | (wdata & m);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        if (a == OFS_BRIDGE_SUPPORT_EXT) begin
            hit = 1'b1;
        end else if (a == OFS_MEM0_XLAT_BASE) begin
            hit = 1'b1;
        end else if (a == OFS_MEM0_WIN_SETUP) begin
            hit = 1'b1;
        end else if (a == OFS_SLOT_IDENT) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // Bus handshake: one wait cycle, then the answer
    assign req_taken = (avs_req.read | avs_req.write) & ~ack_ff;
    assign wr_done = avs_req.write & ack_ff;
    assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack_ff;
    assign avs_readdata = avs_readdata_ff;
    assign avs_response = avs_response_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req_taken;
        end
    end

    // Base bits under the window mask; the top bit follows enable
    assign win_mask = {setup_ff.enable, setup_ff.size_mask};

    assign slot_word = {chassis_ff, 2'b00, first_ff, slot_num_ff,
                        SLOT_NEXT_LINK, SLOT_CAP_CODE};

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_mapped = is_mapped(avs_req.address);
        if (avs_req.address == OFS_BRIDGE_SUPPORT_EXT) begin
            rd_word[BSE_B2B3_BIT] = 1'b0;
            rd_word[BSE_BUS_PWR_BIT] = 1'b0;
            rd_word[31:24] = BSE_DATA_RESET;
        end else if (avs_req.address == OFS_MEM0_XLAT_BASE) begin
            rd_word = {xbase_ff, 12'h000};
        end else if (avs_req.address == OFS_MEM0_WIN_SETUP) begin
            rd_word[SETUP_TYPE_BIT] = 1'b0;
            rd_word[SETUP_ATYPE_LSB +: 2] = setup_ff.addr_type;
            rd_word[SETUP_PREF_BIT] = setup_ff.prefetch;
            rd_word[SETUP_SIZE_LSB +: 19] = setup_ff.size_mask;
            rd_word[SETUP_EN_BIT] = setup_ff.enable;
        end else if (avs_req.address == OFS_SLOT_IDENT) begin
            rd_word = slot_word;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata_ff <= 32'h0000_0000;
            avs_response_ff <= RESP_OKAY;
        end else if (req_taken) begin
            avs_readdata_ff <= avs_req.read ? rd_word : 32'h0000_0000;
            avs_response_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // only mask-enabled base bits take writes
    assign base_merged = merge_word({xbase_ff, 12'h000}, avs_req.writedata,
                                    avs_req.byteenable, {win_mask, 12'h000});

    always_comb begin
        nxt_xbase = xbase_ff;
        if (wr_done && avs_req.address == OFS_MEM0_XLAT_BASE) begin
            nxt_xbase = base_merged[31:12];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            xbase_ff <= XLAT_BASE_RESET;
        end else begin
            xbase_ff <= nxt_xbase;
        end
    end

    // setup changes only on the initialization path
    always_comb begin
        nxt_setup = setup_ff;
        if (init_wr_en) begin
            nxt_setup = init_setup;
            nxt_setup.enable = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            setup_ff.enable <= EN_RESET;
            setup_ff.size_mask <= SIZE_MASK_RESET;
            setup_ff.prefetch <= PREF_RESET;
            setup_ff.addr_type <= ATYPE_32BIT;
        end else begin
            setup_ff <= nxt_setup;
        end
    end

    // slot number and first flag in enabled lanes
    assign slot_merged = merge_word(slot_word, avs_req.writedata,
                                    avs_req.byteenable,
                                    32'hff3f_0000);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slot_num_ff <= SLOT_NUM_RESET;
            first_ff <= 1'b0;
        end else if (wr_done && avs_req.address == OFS_SLOT_IDENT) begin
            slot_num_ff <= slot_merged[SLOT_NUM_LSB +: 5];
            first_ff <= slot_merged[SLOT_FIRST_BIT];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chassis_ff <= CHASSIS_RESET;
        end else if (wr_done && avs_req.address == OFS_SLOT_IDENT) begin
            chassis_ff <= slot_merged[CHASSIS_LSB +: 8];
        end
    end

    // masked base bits replace initiator bits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dn_hit_ff <= 1'b0;
            xlat_addr_ff <= 32'h0000_0000;
        end else begin
            dn_hit_ff <= dn_valid & setup_ff.enable &
                ((dn_addr[31:12] & win_mask) ==
                 (win_base[31:12] & win_mask));
            xlat_addr_ff <= {(dn_addr[31:12] & ~win_mask) |
                             (xbase_ff & win_mask), dn_addr[11:0]};
        end
    end

    // sizing view of the window base register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bar_rw_mask_ff <= 32'h0000_0000;
            bar_size_read_ff <= 32'h0000_0000;
        end else begin
            bar_rw_mask_ff <= {win_mask, 12'h000};
            bar_size_read_ff <= {win_mask, 8'h00, setup_ff.prefetch,
                                 setup_ff.addr_type, 1'b0};
        end
    end

    sequence s_read_at(logic [7:0] a);
        avs_req.read && !ack_ff && avs_req.address == a;
    endsequence

    sequence s_write_done_at(logic [7:0] a);
        avs_req.write && ack_ff && avs_req.address == a;
    endsequence

    a_wait_one_cycle: assert property (
        @(posedge clk) disable iff (sys_rst)
        (avs_req.read || avs_req.write) && !ack_ff
        |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("waitrequest not released after one cycle");

    a_bse_reads_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_read_at(OFS_BRIDGE_SUPPORT_EXT)
        |=> avs_readdata[BSE_B2B3_BIT] == 1'b0
            && avs_readdata[BSE_BUS_PWR_BIT] == 1'b0)
        else $error("support extension bits not zero");

    a_bse_data_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_read_at(OFS_BRIDGE_SUPPORT_EXT)
        |=> avs_readdata[31:24] == 8'h00 && avs_response == RESP_OKAY)
        else $error("data byte not zero");

    a_base_low_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_read_at(OFS_MEM0_XLAT_BASE)
        |=> avs_readdata[11:0] == 12'h000
            && avs_readdata[31:12] == $past(xbase_ff))
        else $error("base read wrong");

    a_base_masked: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_write_done_at(OFS_MEM0_XLAT_BASE) ##0 avs_req.byteenable == 4'hf
        |=> xbase_ff == (($past(xbase_ff) & ~$past(win_mask)) |
                         ($past(avs_req.writedata[31:12]) &
                          $past(win_mask))))
        else $error("base write ignored the size mask");

    a_setup_ro_bus: assert property (
        @(posedge clk) disable iff (sys_rst)
        !init_wr_en |=> $stable(setup_ff))
        else $error("setup changed without init write");

    a_enable_held: assert property (
        @(posedge clk) disable iff (sys_rst)
        setup_ff.enable == 1'b1)
        else $error("window enable cleared");

    a_setup_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_read_at(OFS_MEM0_WIN_SETUP)
        |=> avs_readdata[SETUP_TYPE_BIT] == 1'b0
            && avs_readdata[11:4] == 8'h00
            && avs_readdata[2:1] == $past(setup_ff.addr_type))
        else $error("setup read wrong");

    a_slot_consts: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_read_at(OFS_SLOT_IDENT)
        |=> avs_readdata[15:0] == 16'hb004
            && avs_readdata[23:22] == 2'b00)
        else $error("slot capability constants wrong");

    a_chassis_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_write_done_at(OFS_SLOT_IDENT) ##0 avs_req.byteenable[3]
        |=> chassis_ff == $past(avs_req.writedata[31:24]))
        else $error("chassis number not written");

    a_xlat_addr: assert property (
        @(posedge clk) disable iff (sys_rst)
        dn_valid |=> xlat_addr_ff[11:0] == $past(dn_addr[11:0])
            && xlat_addr_ff[31:12] ==
               (($past(dn_addr[31:12]) & ~$past(win_mask)) |
                ($past(xbase_ff) & $past(win_mask))))
        else $error("translated address wrong");

    a_size_view: assert property (
        @(posedge clk) disable iff (sys_rst)
        1'b1 |=> bar_size_read_ff[31:12] == $past(win_mask)
            && bar_size_read_ff[3] == $past(setup_ff.prefetch))
        else $error("sizing view wrong");

    a_slot_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_write_done_at(OFS_SLOT_IDENT) ##0 avs_req.byteenable[2]
        |=> slot_num_ff == $past(avs_req.writedata[20:16])
            && first_ff == $past(avs_req.writedata[21]))
        else $error("slot number not written");

    a_no_idle_hit: assert property (
        @(posedge clk) disable iff (sys_rst)
        !dn_valid |=> !dn_hit_ff)
        else $error("window hit without a valid address");

endmodule

`default_nettype wire

// [shared/bridge_cfg_pkg.sv]
// Package for the bridge translation and slot identification registers.
// Assumes byte addresses on an 8-bit Avalon-MM address, one word each.
package bridge_cfg_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_BRIDGE_SUPPORT_EXT = 8'h94;
    localparam logic [7:0] OFS_MEM0_XLAT_BASE = 8'h98;
    localparam logic [7:0] OFS_MEM0_WIN_SETUP = 8'h9c;
    localparam logic [7:0] OFS_SLOT_IDENT = 8'ha0;

    // Bridge support extension fields
    localparam int BSE_B2B3_BIT = 22;
    localparam int BSE_BUS_PWR_BIT = 23;
    localparam logic [7:0] BSE_DATA_RESET = 8'h00;

    // Translated base fields
    localparam int XLAT_BASE_LSB = 12;
    localparam logic [19:0] XLAT_BASE_RESET = 20'h00000;

    // Window setup fields
    localparam int SETUP_TYPE_BIT = 0;
    localparam int SETUP_ATYPE_LSB = 1;
    localparam int SETUP_PREF_BIT = 3;
    localparam int SETUP_SIZE_LSB = 12;
    localparam int SETUP_EN_BIT = 31;
    localparam logic [1:0] ATYPE_32BIT = 2'h0;
    localparam logic [1:0] ATYPE_64BIT = 2'h1;
    localparam logic [18:0] SIZE_MASK_RESET = 19'h7ffff;
    localparam logic PREF_RESET = 1'b0;
    localparam logic EN_RESET = 1'b1;

    // Slot identification fields
    localparam logic [7:0] SLOT_CAP_CODE = 8'h04;
    localparam logic [7:0] SLOT_NEXT_LINK = 8'hb0;
    localparam int SLOT_NUM_LSB = 16;
    localparam int SLOT_FIRST_BIT = 21;
    localparam int CHASSIS_LSB = 24;
    localparam logic [4:0] SLOT_NUM_RESET = 5'h00;
    localparam logic [7:0] CHASSIS_RESET = 8'h00;

    // Avalon-MM response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic enable;
        logic [18:0] size_mask;
        logic prefetch;
        logic [1:0] addr_type;
    } win_setup_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } avs_req_t;

endpackage

// [testbench/tb_bridge_cfg_translation_slot_regs.sv]
// Self-checking bench for the translation and slot identification registers.
// Assumes the register block is driven alone, one Avalon-MM master here.
`timescale 1ns/1ps
`default_nettype none

module tb_bridge_cfg_translation_slot_regs;
    import bridge_cfg_pkg::*;

    logic clk, sys_rst, init_wr_en, dn_valid, avs_waitrequest, dn_hit_ff;
    avs_req_t avs_req;
    win_setup_t init_setup;
    logic [31:0] dn_addr, win_base, avs_readdata, xlat_addr_ff;
    logic [31:0] bar_rw_mask_ff, bar_size_read_ff, rdata;
    logic [1:0] avs_response, rresp;
    int fail_count, n_compared;

    bridge_cfg_translation_slot_regs dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .avs_req(avs_req),
        .avs_readdata(avs_readdata),
        .avs_response(avs_response),
        .avs_waitrequest(avs_waitrequest),
        .init_wr_en(init_wr_en),
        .init_setup(init_setup),
        .dn_valid(dn_valid),
        .dn_addr(dn_addr),
        .win_base(win_base),
        .dn_hit_ff(dn_hit_ff),
        .xlat_addr_ff(xlat_addr_ff),
        .bar_rw_mask_ff(bar_rw_mask_ff),
        .bar_size_read_ff(bar_size_read_ff)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task close_out();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus cycle; held until waitrequest is seen low, then released
    task bus(input logic wr, input logic [7:0] a, input logic [3:0] be,
             input logic [31:0] d);
        int n;
        avs_req <= {~wr, wr, a, be, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            close_out();
        end
        rdata = avs_readdata;
        rresp = avs_response;
        avs_req <= '0;
        @(posedge clk);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp,
                input logic [1:0] er);
        bus(1'b0, a, 4'hf, 32'h0);
        chk_word(rdata, exp);
        chk_resp(rresp, er);
    endtask

    task init_load(input logic pf, input logic [1:0] at);
        init_setup <= '{enable: 1'b0, size_mask: 19'h7ff00, prefetch: pf,
                        addr_type: at};
        init_wr_en <= 1'b1;
        @(posedge clk);
        init_wr_en <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task xlate(input logic [31:0] a, input logic hit, input logic [31:0] exp);
        dn_valid <= 1'b1;
        dn_addr <= a;
        @(posedge clk);
        @(negedge clk);
        chk_flag(dn_hit_ff, hit);
        if (hit) begin
            chk_word(xlat_addr_ff, exp);
        end
        @(posedge clk);
        dn_valid <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        sys_rst = 1'b1;
        init_wr_en = 1'b0;
        dn_valid = 1'b0;
        dn_addr = 32'h0;
        win_base = 32'ha000_0000;
        avs_req = '0;
        init_setup = '0;
        fail_count = 0;
        n_compared = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_word(bar_rw_mask_ff, 32'hffff_f000);
        chk_word(bar_size_read_ff, 32'hffff_f000);
        @(posedge clk);
        rd_chk(8'h94, 32'h0, 2'h0);
        rd_chk(8'h98, 32'h0, 2'h0);
        rd_chk(8'h9c, 32'hffff_f000, 2'h0);
        rd_chk(8'ha0, 32'h0000_b004, 2'h0);
        bus(1'b1, 8'h94, 4'hf, 32'hffff_ffff);
        rd_chk(8'h94, 32'h0, 2'h0);
        bus(1'b1, 8'ha0, 4'hf, 32'hffff_ffff);
        rd_chk(8'ha0, 32'hff3f_b004, 2'h0);
        bus(1'b1, 8'ha0, 4'h4, 32'h0);
        rd_chk(8'ha0, 32'hff00_b004, 2'h0);
        bus(1'b1, 8'h98, 4'hf, 32'hffff_ffff);
        rd_chk(8'h98, 32'hffff_f000, 2'h0);
        bus(1'b1, 8'h98, 4'h8, 32'h0);
        rd_chk(8'h98, 32'h00ff_f000, 2'h0);
        bus(1'b1, 8'h98, 4'hf, 32'h0);
        bus(1'b1, 8'h9c, 4'hf, 32'h0);
        rd_chk(8'h9c, 32'hffff_f000, 2'h0);
        rd_chk(8'h50, 32'h0, 2'h2);
        bus(1'b1, 8'h50, 4'hf, 32'h1234_5678);
        chk_resp(rresp, 2'h2);
        // Every address type and prefetch setting through the init path
        for (int i = 0; i < 4; i++) begin
            init_load(i[1], {1'b0, i[0]});
            rd_chk(8'h9c, {12'hfff, 16'h0, i[1], 1'b0, i[0], 1'b0},
                   2'h0);
        end
        @(negedge clk);
        chk_word(bar_rw_mask_ff, 32'hfff0_0000);
        chk_word(bar_size_read_ff, 32'hfff0_000a);
        @(posedge clk);
        bus(1'b1, 8'h98, 4'hf, 32'h1234_5678);
        rd_chk(8'h98, 32'h1230_0000, 2'h0);
        xlate(32'ha004_5678, 1'b1, 32'h1234_5678);
        xlate(32'hb004_5678, 1'b0, 32'h0);
        close_out();
    end

    initial begin
        #200000;
        fail_count++;
        close_out();
    end
endmodule

`default_nettype wire
